/* File: dspace_pkg.sv */
package dspace_pkg;

    // ==========================================================
    // address spaces and widths
    localparam int DATA_AW = 8;
    localparam int PROG_AW = 12;
    localparam int STACK_DEPTH = 6;
    localparam int WIN_LOW_BITS = 6;
    localparam int RAM_WORDS = 60;

    // ==========================================================
    // data-space decode boundaries
    localparam logic [7:0] WIN_FIRST = 8'h40;
    localparam logic [7:0] WIN_LAST = 8'h7F;
    localparam logic [7:0] RAM_FIRST = 8'h84;
    localparam logic [7:0] RAM_LAST = 8'hBF;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_POINTER_X = 8'h80;
    localparam logic [7:0] OFS_POINTER_Y = 8'h81;
    localparam logic [7:0] OFS_SHORT_DIRECT_V = 8'h82;
    localparam logic [7:0] OFS_SHORT_DIRECT_W = 8'h83;
    localparam logic [7:0] OFS_PORTA_VALUE = 8'hC0;
    localparam logic [7:0] OFS_PORTB_VALUE = 8'hC1;
    localparam logic [7:0] OFS_PORTA_DIR = 8'hC4;
    localparam logic [7:0] OFS_PORTB_DIR = 8'hC5;
    localparam logic [7:0] OFS_IRQ_OPTIONS = 8'hC8;
    localparam logic [7:0] OFS_ROM_WINDOW_BASE = 8'hC9;
    localparam logic [7:0] OFS_PORTA_CONFIG = 8'hCC;
    localparam logic [7:0] OFS_PORTB_CONFIG = 8'hCD;
    localparam logic [7:0] OFS_CONV_RESULT = 8'hD0;
    localparam logic [7:0] OFS_CONV_CONTROL = 8'hD1;
    localparam logic [7:0] OFS_TMR_PRESCALE = 8'hD2;
    localparam logic [7:0] OFS_TMR_COUNT = 8'hD3;
    localparam logic [7:0] OFS_TMR_STATUS_CTRL = 8'hD4;
    localparam logic [7:0] OFS_WATCHDOG_COUNT = 8'hD8;
    localparam logic [7:0] OFS_ACCUMULATOR = 8'hFF;

    // ==========================================================
    // reset values and read answers
    localparam logic [7:0] CORE_REG_RESET = 8'h00;
    localparam logic [7:0] RESERVED_READ = 8'h00;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [7:0] PROT_READ = 8'h00;
    localparam int PROT_BIT = 3;

    // option byte load: cycles spent reading each byte
    localparam int OPT_LOAD_CYCLES = 2;

    // ==========================================================
    // decode regions
    typedef enum {
        RG_RESERVED, RG_WINDOW, RG_CORE, RG_RAM, RG_PERIPH, RG_WO, RG_ACC
    } region_t;

    // startup sequencer states
    typedef enum {
        ST_OPT_LO, ST_OPT_HI, ST_RUN, ST_PROG
    } boot_t;

    // core data-bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dbus_req_t;

    // option bytes as one word
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } opt_word_t;

endpackage : dspace_pkg

/* File: dspace_ram.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// small synchronous data ram with registered read data
module dspace_ram
    import dspace_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // access
    input wire logic wr_en,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] mem [RAM_WORDS];

    // write port, no reset: ram content is undefined at power-up
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
    end

    // read port registered
    always_ff @(posedge sys_clk) begin
        rdata <= mem[addr];
    end

endmodule : dspace_ram

`default_nettype wire

/* File: dspace_decoder.sv */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - separate program, data and stack spaces
// - program space addressed by 12-bit counter
// - stack is six 12-bit return registers
// - data 40h-7Fh reads program memory window
// - window base high bits, address low six
// - window base holds bits 5..0 only
// - window base write-only at C9h, no bit ops
// - reset does not clear window base
// - data space holds ram, core, peripheral registers
// - port data, direction, option register slots
// - converter, timer, watchdog register slots
// - interrupt options write-only at C8h
// - reset reads both option bytes first
// - option bytes only in programming mode
// - programming mode only if test high at reset
// - protection blocks external program readout
// - protect bit high blocks, low allows readout
// - accumulator FFh, pointers 80h-83h, like ram
module dspace_decoder
    import dspace_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // core data bus
    input wire dbus_req_t dreq,
    output logic [7:0] drdata,
    output logic drvalid,
    output logic dsel_periph,
    // core program counter and stack control
    input wire logic pc_load,
    input wire logic [11:0] pc_load_val,
    input wire logic pc_inc,
    input wire logic stk_push,
    input wire logic stk_pop,
    output logic [11:0] pc,
    output logic [11:0] stk_top,
    // program memory read port
    output logic [11:0] pmem_addr,
    output logic pmem_rd,
    input wire logic [7:0] pmem_rdata,
    // peripheral register side
    input wire logic [7:0] periph_rdata,
    output logic [7:0] irq_options,
    output logic [5:0] window_base_bits,
    // test pin level at reset and external readout port
    input wire logic test_prog_level,
    input wire logic ext_rd,
    input wire logic [11:0] ext_addr,
    output logic [7:0] ext_rdata,
    output logic ext_rvalid,
    // option byte status
    output logic [15:0] opt_bytes,
    output logic prog_mode,
    output logic core_ready
);

    // ==========================================================
    // peripheral slot map; holes between slots stay reserved
    function automatic logic periph_slot(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            OFS_PORTA_VALUE, OFS_PORTB_VALUE: hit = 1'b1;
            OFS_PORTA_DIR, OFS_PORTB_DIR: hit = 1'b1;
            OFS_PORTA_CONFIG, OFS_PORTB_CONFIG: hit = 1'b1;
            OFS_CONV_RESULT, OFS_CONV_CONTROL: hit = 1'b1;
            OFS_TMR_PRESCALE, OFS_TMR_COUNT, OFS_TMR_STATUS_CTRL: hit = 1'b1;
            OFS_WATCHDOG_COUNT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : periph_slot

    // decode function, used for both write and read paths
    // first match wins; whatever is left over is reserved,
    // so it takes no write and reads back as zero
    function automatic region_t decode(input logic [7:0] a);
        region_t r;
        r = RG_RESERVED;
        if (a >= WIN_FIRST && a <= WIN_LAST) r = RG_WINDOW;
        else if (a >= OFS_POINTER_X && a <= OFS_SHORT_DIRECT_W) r = RG_CORE;
        else if (a >= RAM_FIRST && a <= RAM_LAST) r = RG_RAM;
        else if (a == OFS_IRQ_OPTIONS || a == OFS_ROM_WINDOW_BASE) r = RG_WO;
        else if (a == OFS_ACCUMULATOR) r = RG_ACC;
        else if (periph_slot(a)) r = RG_PERIPH;
        return r;
    endfunction : decode

    // decode result and run qualifier
    region_t reg_now;
    boot_t boot_r;
    logic run;

    // core-side byte stores and ram port
    logic [7:0] core_regs_r [4];
    logic [7:0] acc_r;
    logic [7:0] ram_rdata;
    logic ram_we;

    // read answer bookkeeping
    logic [2:0] rd_src_r;
    logic [1:0] core_idx_r;

    // startup, stack and readout state
    logic opt_cnt_r;
    logic [11:0] stack_r [STACK_DEPTH];
    logic [2:0] sp_r;
    logic ext_pend_r;

    // nothing on the core bus counts until option load is done
    assign reg_now = decode(dreq.addr);
    assign run = (boot_r == ST_RUN);
    // reserved and write-only slots never reach the ram
    assign ram_we = run && dreq.wr && reg_now == RG_RAM;

    // ==========================================================
    // startup: strap test pin while the low option byte loads, then fetch the high byte
    // the core stays held until both bytes are in, so no
    // option is ever acted on half loaded
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_r <= ST_OPT_LO;
            opt_cnt_r <= 1'b0;
            opt_bytes <= 16'h0000;
            prog_mode <= 1'b0;
            core_ready <= 1'b0;
        end else begin
            case (boot_r)
                ST_OPT_LO: begin
                    // test level sampled in both ST_OPT_LO cycles after release; the second cycle's level is kept
                    prog_mode <= test_prog_level;
                    opt_cnt_r <= ~opt_cnt_r;
                    if (opt_cnt_r) begin
                        opt_bytes[7:0] <= pmem_rdata;
                        boot_r <= ST_OPT_HI;
                    end
                end
                ST_OPT_HI: begin
                    opt_cnt_r <= ~opt_cnt_r;
                    if (opt_cnt_r) begin
                        opt_bytes[15:8] <= pmem_rdata;
                        boot_r <= prog_mode ? ST_PROG : ST_RUN;
                        // core released only in normal mode
                        core_ready <= ~prog_mode;
                    end
                end
                ST_RUN: boot_r <= ST_RUN;
                ST_PROG: boot_r <= ST_PROG;
                default: boot_r <= ST_OPT_LO;
            endcase
        end
    end

    // ==========================================================
    // program counter, 12 bits wide
    // a load wins over an increment in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_RESET;
        end else if (run) begin
            if (pc_load) pc <= pc_load_val;
            else if (pc_inc) pc <= pc + 12'h001;
        end
    end

    // ==========================================================
    // six-deep return stack, separate space from data
    // depth count only guards pops; a push past six drops
    // the oldest entry off the bottom
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= 3'h0;
        end else if (run) begin
            if (stk_push && !stk_pop && sp_r != 3'(STACK_DEPTH)) sp_r <= sp_r + 3'h1;
            else if (stk_pop && !stk_push && sp_r != 3'h0) sp_r <= sp_r - 3'h1;
        end
    end

    // stack storage, shifts so the top is always entry 0
    // an empty stack ignores pops and keeps answering zero
    genvar gi;
    generate
        for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stack_r[gi] <= PC_RESET;
                end else if (run && stk_push) begin
                    stack_r[gi] <= (gi == 0) ? pc : stack_r[(gi == 0) ? 0 : gi - 1];
                end else if (run && stk_pop && sp_r != 3'h0) begin
                    stack_r[gi] <= (gi == STACK_DEPTH - 1) ? PC_RESET : stack_r[(gi == STACK_DEPTH - 1) ? gi : gi + 1];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) stk_top <= PC_RESET;
        else stk_top <= stack_r[0];
    end

    // ==========================================================
    // window base: write-only, no reset on purpose
    // an unwritten base is unknown, so window reads before
    // the first write return whatever the base points at
    // bit ops refused since a read-modify-write cannot see the old value
    always_ff @(posedge sys_clk) begin
        if (run && dreq.wr && !dreq.bit_op && dreq.addr == OFS_ROM_WINDOW_BASE) begin
            window_base_bits <= dreq.wdata[5:0];  // bits 7..6 dropped
        end
    end

    // interrupt options, write-only
    // no read path: a read of this slot answers zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) irq_options <= CORE_REG_RESET;
        else if (run && dreq.wr && dreq.addr == OFS_IRQ_OPTIONS) irq_options <= dreq.wdata;
    end

    // ==========================================================
    // pointer and short-direct registers, plus accumulator
    // bit writes arrive as whole bytes, so they land like any write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) core_regs_r[i] <= CORE_REG_RESET;
            acc_r <= CORE_REG_RESET;
        end else if (run && dreq.wr) begin
            if (reg_now == RG_CORE) core_regs_r[dreq.addr[1:0]] <= dreq.wdata;
            if (reg_now == RG_ACC) acc_r <= dreq.wdata;
        end
    end

    // ram index is the offset from the first ram byte, cut
    // to six bits on purpose; decode keeps writes in range
    dspace_ram u_ram (
        .sys_clk(sys_clk),
        .wr_en(ram_we),
        .addr(6'(dreq.addr - RAM_FIRST)),
        .wdata(dreq.wdata),
        .rdata(ram_rdata)
    );

    // ==========================================================
    // program memory port: boot fetch, window read, external read
    // window and readout never compete: readout exists only
    // while the core is held in programming mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pmem_addr <= 12'h000;
            pmem_rd <= 1'b0;
            ext_pend_r <= 1'b0;
        end else begin
            pmem_rd <= 1'b0;
            ext_pend_r <= 1'b0;
            if (boot_r == ST_OPT_LO || boot_r == ST_OPT_HI) begin
                // option bytes sit outside the user map; no address needed
                pmem_addr <= 12'h000;
                pmem_rd <= 1'b1;
            end else if (run && dreq.rd && reg_now == RG_WINDOW) begin
                pmem_addr <= {window_base_bits, dreq.addr[5:0]};
                pmem_rd <= 1'b1;
            end else if (boot_r == ST_PROG && ext_rd) begin
                pmem_addr <= ext_addr;
                pmem_rd <= 1'b1;
                ext_pend_r <= 1'b1;
            end
        end
    end

    // external readout gated by protect bit
    // a protected read still pulses valid, so the programmer
    // sees a blank byte rather than a hang
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_rdata <= PROT_READ;
            ext_rvalid <= 1'b0;
        end else begin
            ext_rvalid <= ext_pend_r;
            if (ext_pend_r) ext_rdata <= opt_bytes[8 + PROT_BIT] ? PROT_READ : pmem_rdata;
        end
    end

    // ==========================================================
    // read source tracking, answer one cycle after the ram/pmem fetch
    // source codes: 0 idle, 1 window, 2 ram, 3 core regs 80h-83h, 4 acc,
    // 5 peripheral, 6 zero for reserved and write-only slots
    // peripheral select pulses on writes too, so a slot can latch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_src_r <= 3'h0;
            core_idx_r <= 2'h0;
            dsel_periph <= 1'b0;
        end else begin
            rd_src_r <= 3'h0;
            dsel_periph <= 1'b0;
            if (run && (dreq.rd || dreq.wr)) begin
                dsel_periph <= (reg_now == RG_PERIPH);
            end
            if (run && dreq.rd) begin
                core_idx_r <= dreq.addr[1:0];
                case (reg_now)
                    RG_WINDOW: rd_src_r <= 3'h1;
                    RG_RAM: rd_src_r <= 3'h2;
                    RG_CORE: rd_src_r <= 3'h3;
                    RG_ACC: rd_src_r <= 3'h4;
                    RG_PERIPH: rd_src_r <= 3'h5;
                    default: rd_src_r <= 3'h6;  // reserved and write-only
                endcase
            end
        end
    end

    // read answer register
    // drdata drops back to zero between reads; only drvalid marks a fresh byte
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drdata <= RESERVED_READ;
            drvalid <= 1'b0;
        end else begin
            drvalid <= (rd_src_r != 3'h0);
            case (rd_src_r)
                3'h1: drdata <= pmem_rdata;
                3'h2: drdata <= ram_rdata;
                3'h3: drdata <= core_regs_r[core_idx_r];
                3'h4: drdata <= acc_r;
                3'h5: drdata <= periph_rdata;
                default: drdata <= RESERVED_READ;
            endcase
        end
    end

endmodule : dspace_decoder

`default_nettype wire

/* File: dspace_decoder_asserts.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// port-level checker for the data-space decoder
module dspace_decoder_asserts
    import dspace_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // core data bus
    input wire dbus_req_t dreq,
    input wire logic [7:0] drdata,
    input wire logic drvalid,
    input wire logic dsel_periph,
    // program memory and stores
    input wire logic [11:0] pmem_addr,
    input wire logic pmem_rd,
    input wire logic [7:0] irq_options,
    input wire logic [5:0] window_base_bits,
    // readout and startup
    input wire logic ext_rd,
    input wire logic [7:0] ext_rdata,
    input wire logic ext_rvalid,
    input wire logic [15:0] opt_bytes,
    input wire logic prog_mode,
    input wire logic core_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic take_rd;
    logic take_wr;
    logic is_periph;
    // requests only count once the core is released
    assign take_rd = dreq.rd && core_ready;
    assign take_wr = dreq.wr && core_ready;

    // peripheral slots, gaps between them stay reserved
    always_comb begin
        case (dreq.addr)
            8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD: is_periph = 1'b1;
            8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD8: is_periph = 1'b1;
            default: is_periph = 1'b0;
        endcase
    end

    // window fetch: concatenated address, then the answer
    sequence win_fetch;
        pmem_rd && pmem_addr == {window_base_bits, $past(dreq.addr[5:0])} ##1 drvalid;
    endsequence

    win_addr_a: assert property (take_rd && dreq.addr inside {[8'h40:8'h7F]} |=> win_fetch)
        else $error("window read formed wrong program address");
    rd_answer_a: assert property (take_rd |-> ##2 drvalid)
        else $error("read answer missing two cycles after request");
    wo_read_a: assert property (take_rd && dreq.addr inside {8'hC8, 8'hC9} |-> ##2 drdata == 8'h00)
        else $error("write-only read exposed contents");
    rsv_read_a: assert property (take_rd && dreq.addr < 8'h40 |-> ##2 drdata == 8'h00)
        else $error("reserved read not zero");
    base_bitop_a: assert property (take_wr && dreq.bit_op && dreq.addr == 8'hC9 |=> $stable(window_base_bits))
        else $error("bit write changed window base");
    base_write_a: assert property (take_wr && !dreq.bit_op && dreq.addr == 8'hC9
        |=> window_base_bits == $past(dreq.wdata[5:0]))
        else $error("window base not loaded from low six bits");
    irq_write_a: assert property (take_wr && dreq.addr == 8'hC8 |=> irq_options == $past(dreq.wdata))
        else $error("interrupt options not stored");
    periph_sel_a: assert property (take_rd || take_wr |=> dsel_periph == $past(is_periph))
        else $error("peripheral select disagrees with slot map");
    ext_prot_a: assert property (prog_mode && ext_rd && opt_bytes[11] |-> ##2 ext_rvalid && ext_rdata == 8'h00)
        else $error("protected readout leaked data");
    prog_idle_a: assert property (prog_mode |-> !core_ready)
        else $error("core released in programming mode");
endmodule : dspace_decoder_asserts

bind dspace_decoder dspace_decoder_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .dreq(dreq),
    .drdata(drdata), .drvalid(drvalid), .dsel_periph(dsel_periph), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .irq_options(irq_options), .window_base_bits(window_base_bits), .ext_rd(ext_rd), .ext_rdata(ext_rdata),
    .ext_rvalid(ext_rvalid), .opt_bytes(opt_bytes), .prog_mode(prog_mode), .core_ready(core_ready));

`default_nettype wire

/* File: pmem_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// program memory read port, data valid in read cycle and the next
module pmem_model (
    // clock
    input wire logic sys_clk,
    // read port
    input wire logic [11:0] pmem_addr,
    input wire logic pmem_rd,
    input wire logic [7:0] boot_byte,
    output logic [7:0] pmem_rdata
);
    logic [7:0] hold_r;
    logic [7:0] word;

    // address hash as content; location 000 carries the option byte
    assign word = (pmem_addr == 12'h000) ? boot_byte : (pmem_addr[7:0] ^ {pmem_addr[11:8], 4'h5});

    // after the hold cycle the bus inverts every cycle, so stale data matches only every other cycle
    always @(posedge sys_clk) begin
        hold_r <= pmem_rd ? word : ~hold_r;
    end
    assign pmem_rdata = pmem_rd ? word : hold_r;
endmodule : pmem_model

`default_nettype wire

/* File: data_space_decoder_rom_window_bench.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// self-checking bench for the data-space decoder
module data_space_decoder_rom_window_bench;
    import dspace_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    dbus_req_t dreq = '0;
    logic pc_load = 1'b0, pc_inc = 1'b0, stk_push = 1'b0, test_prog_level = 1'b0, ext_rd = 1'b0;
    logic stk_pop = 1'b0;
    logic [11:0] pc_load_val = 12'h000, ext_addr = 12'h000, pc, stk_top, pmem_addr;
    logic [7:0] periph_rdata = 8'h00, boot_byte = 8'h00, pmem_rdata, drdata, irq_options, ext_rdata;
    logic drvalid, dsel_periph, pmem_rd, ext_rvalid, prog_mode, core_ready, seen_sel;
    logic [5:0] window_base_bits;
    logic [15:0] opt_bytes;
    logic [11:0] seen_pa;
    int err_count = 0;
    int tests_run = 0;

    always #5 sys_clk = ~sys_clk;

    // ==========================================================
    // design and program memory
    dspace_decoder i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .dreq(dreq), .drdata(drdata), .drvalid(drvalid),
        .dsel_periph(dsel_periph), .pc_load(pc_load), .pc_load_val(pc_load_val), .pc_inc(pc_inc),
        .stk_push(stk_push), .stk_pop(stk_pop), .pc(pc), .stk_top(stk_top), .pmem_addr(pmem_addr),
        .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata), .periph_rdata(periph_rdata), .irq_options(irq_options),
        .window_base_bits(window_base_bits), .test_prog_level(test_prog_level), .ext_rd(ext_rd),
        .ext_addr(ext_addr), .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid), .opt_bytes(opt_bytes),
        .prog_mode(prog_mode), .core_ready(core_ready));
    pmem_model i_mem (.sys_clk(sys_clk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .boot_byte(boot_byte),
        .pmem_rdata(pmem_rdata));

    // ==========================================================
    // shared helpers
    function automatic logic [7:0] rom(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction : rom

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // inputs always move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic acc(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d);
        dreq = '{rd: !w, wr: w, bit_op: b, addr: a, wdata: d};
        tick(1);
        dreq = '0;
        // a write lets one idle edge pass, so the next request
        // never rewrites dreq in the same time step
        if (w) tick(1);
    endtask : acc

    // read: address and select stand after the taking edge, answer one edge on
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        acc(1'b0, 1'b0, a, 8'h00);
        seen_pa = pmem_addr;
        seen_sel = dsel_periph;
        tick(1);
        chk("drvalid", 16'h0001, {15'h0, drvalid});
        q = drdata;
    endtask : rd

    task automatic boot(input logic prog, input logic [15:0] ob);
        rst_n = 1'b0;
        test_prog_level = prog;
        boot_byte = ob[7:0];
        tick(6);
        rst_n = 1'b1;
        tick(2);
        boot_byte = ob[15:8];
        tick(2);
        chk("opt_bytes", ob, opt_bytes);
        chk("prog_mode", {15'h0, prog}, {15'h0, prog_mode});
        chk("core_ready", {15'h0, !prog}, {15'h0, core_ready});
    endtask : boot

    // ==========================================================
    // scenarios
    task automatic t_stack();
        pc_load = 1'b1;
        pc_load_val = 12'hA5C;
        tick(1);
        pc_load = 1'b0;
        chk("pc", 16'h0A5C, {4'h0, pc});
        stk_push = 1'b1;
        tick(1);
        stk_push = 1'b0;
        pc_inc = 1'b1;
        tick(1);
        pc_inc = 1'b0;
        chk("stk_top", 16'h0A5C, {4'h0, stk_top});
        chk("pc", 16'h0A5D, {4'h0, pc});
        // second level, then pop back to the first
        stk_push = 1'b1;
        tick(1);
        stk_push = 1'b0;
        stk_pop = 1'b1;
        tick(1);
        stk_pop = 1'b0;
        chk("stk_top", 16'h0A5D, {4'h0, stk_top});
        tick(1);
        chk("stk_top", 16'h0A5C, {4'h0, stk_top});
    endtask : t_stack

    task automatic t_window();
        logic [7:0] q;
        logic [7:0] ends [2] = '{8'h40, 8'h7F};
        acc(1'b1, 1'b0, 8'hC9, 8'hC5);
        chk("window_base_bits", 16'h0005, {10'h0, window_base_bits});
        acc(1'b1, 1'b1, 8'hC9, 8'h3A);
        chk("window_base_bits", 16'h0005, {10'h0, window_base_bits});
        rd(8'hC9, q);
        chk("rd C9", 16'h0000, {8'h0, q});
        chk("window_base_bits", 16'h0005, {10'h0, window_base_bits});
        foreach (ends[i]) begin
            rd(ends[i], q);
            chk("pmem_addr", {4'h0, 6'h05, ends[i][5:0]}, {4'h0, seen_pa});
            chk("window data", {8'h0, rom({6'h05, ends[i][5:0]})}, {8'h0, q});
        end
    endtask : t_window

    task automatic t_regs();
        logic [7:0] q;
        logic [7:0] core [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hBF, 8'hFF};
        logic [7:0] rsv [6] = '{8'h00, 8'h3F, 8'hC2, 8'hCA, 8'hD5, 8'hFE};
        logic [7:0] per [12] = '{8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD8};
        foreach (core[i]) acc(1'b1, 1'b0, core[i], core[i] ^ 8'h3C);
        foreach (rsv[i]) acc(1'b1, 1'b0, rsv[i], 8'hFF);
        foreach (core[i]) begin
            rd(core[i], q);
            chk("core reg", {8'h0, core[i] ^ 8'h3C}, {8'h0, q});
        end
        foreach (rsv[i]) begin
            rd(rsv[i], q);
            chk("reserved", 16'h0000, {8'h0, q});
        end
        foreach (per[i]) begin
            periph_rdata = per[i] ^ 8'hA5;
            rd(per[i], q);
            chk("dsel_periph", 16'h0001, {15'h0, seen_sel});
            chk("periph data", {8'h0, per[i] ^ 8'hA5}, {8'h0, q});
        end
        acc(1'b1, 1'b0, 8'hC8, 8'h96);
        chk("irq_options", 16'h0096, {8'h0, irq_options});
        rd(8'hC8, q);
        chk("rd C8", 16'h0000, {8'h0, q});
    endtask : t_regs

    task automatic t_readout(input logic [15:0] ob, input logic [7:0] exp);
        boot(1'b1, ob);
        ext_rd = 1'b1;
        ext_addr = 12'h3A7;
        tick(1);
        ext_rd = 1'b0;
        tick(1);
        chk("ext_rvalid", 16'h0001, {15'h0, ext_rvalid});
        chk("ext_rdata", {8'h0, exp}, {8'h0, ext_rdata});
    endtask : t_readout

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // main sequence and hang guard
    initial begin
        boot(1'b0, 16'h0010);
        t_stack();
        t_window();
        t_regs();
        boot(1'b0, 16'h0010);
        chk("window_base_bits", 16'h0005, {10'h0, window_base_bits});
        t_readout(16'h0810, 8'h00);
        t_readout(16'h0010, rom(12'h3A7));
        report_and_stop();
    end

    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule : data_space_decoder_rom_window_bench

`default_nettype wire
